// File: logic/pfg_pkg.sv
// Package for the periodic flag generator: timing, map and carrier types
package pfg_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned TICK_US       = 10_000;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
	// Half periods, in milliseconds as printed
	localparam int unsigned HALF_20MS_MS  = 10;
	localparam int unsigned HALF_100MS_MS = 50;
	localparam int unsigned HALF_200MS_MS = 100;
	localparam int unsigned HALF_1S_MS    = 500;
	localparam int unsigned HALF_1MIN_MS  = 30_000;
	localparam int unsigned TICK_MS       = TICK_US / 1000;
	localparam int unsigned NUM_FLAGS     = 5;
	// Half periods as counts of 10 ms ticks
	localparam int unsigned HALF_TICKS [NUM_FLAGS] = '{
		HALF_20MS_MS / TICK_MS, HALF_100MS_MS / TICK_MS, HALF_200MS_MS / TICK_MS,
		HALF_1S_MS / TICK_MS, HALF_1MIN_MS / TICK_MS};
	// Register map
	localparam logic [11:0] ADDR_FLAGS    = 12'h000;
	localparam logic [11:0] ADDR_CTRL     = 12'h004;
	localparam logic [11:0] ADDR_TICKS    = 12'h008;
	localparam int unsigned CTRL_RUN_BIT  = 0;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] FLAGS_RESET   = 32'h0000_0000;

	typedef struct packed {
		logic [31:0] prescale;
		logic [31:0] ticks;
		logic [NUM_FLAGS-1:0][15:0] half_cnt;
		logic [NUM_FLAGS-1:0] flags;
		logic        run;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pfg_state_type;
endpackage : pfg_pkg

// File: logic/pfg_top.sv
// Periodic flag generator with APB register access
module pfg_top #(
	parameter int unsigned TICK_CYCLES = pfg_pkg::TICK_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             flag_period_20ms,
	output logic             flag_period_100ms,
	output logic             flag_period_200ms,
	output logic             flag_period_one_second,
	output logic             flag_period_one_minute
);
	localparam int unsigned NF = pfg_pkg::NUM_FLAGS;

	pfg_pkg::pfg_state_type s_q;
	pfg_pkg::pfg_state_type s_d;

	// Read mux shared by the access phase
	function automatic logic [31:0] read_word(input logic [11:0] a,
		input pfg_pkg::pfg_state_type s);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			pfg_pkg::ADDR_FLAGS: r[NF-1:0] = s.flags;
			pfg_pkg::ADDR_CTRL:  r[pfg_pkg::CTRL_RUN_BIT] = s.run;
			pfg_pkg::ADDR_TICKS: r = s.ticks;
			default:             r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return (a == pfg_pkg::ADDR_FLAGS) || (a == pfg_pkg::ADDR_CTRL) ||
			(a == pfg_pkg::ADDR_TICKS);
	endfunction

	logic access;
	logic wr_ctrl;
	logic start;
	logic tick;
	assign access  = psel & penable & ~s_q.pready;
	assign wr_ctrl = access & pwrite & (paddr == pfg_pkg::ADDR_CTRL) & pstrb[0];
	// Run rising edge is the start of operation
	assign start   = wr_ctrl & pwdata[pfg_pkg::CTRL_RUN_BIT] & ~s_q.run;
	assign tick    = s_q.run & (s_q.prescale == TICK_CYCLES - 1);

	// Next state: shared 10 ms time base, per-flag half-period counters
	always_comb begin
		s_d = s_q;
		s_d.pready  = access;
		s_d.pslverr = access & ~mapped(paddr);
		s_d.prdata  = (access & ~pwrite) ? read_word(paddr, s_q) : 32'h0000_0000;
		if (wr_ctrl) begin
			s_d.run = pwdata[pfg_pkg::CTRL_RUN_BIT];
		end
		// Writes to the flag word fall through with no effect
		if (start || !s_q.run) begin
			s_d.prescale = 32'h0000_0000;
			s_d.ticks    = 32'h0000_0000;
			s_d.flags    = '0;
			s_d.half_cnt = '0;
		end else begin
			s_d.prescale = tick ? 32'h0000_0000 : s_q.prescale + 32'h0000_0001;
			if (tick) begin
				s_d.ticks = s_q.ticks + 32'h0000_0001;
			end
			for (int i = 0; i < NF; i++) begin
				// Each flag flips after its half period of ticks
				if (tick) begin
					if (s_q.half_cnt[i] == 16'(pfg_pkg::HALF_TICKS[i] - 1)) begin
						s_d.half_cnt[i] = 16'h0000;
						s_d.flags[i]    = ~s_q.flags[i];
					end else begin
						s_d.half_cnt[i] = s_q.half_cnt[i] + 16'h0001;
					end
				end
			end
		end
	end

	// State register; flags stay low until software sets run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata                 = s_q.prdata;
	assign pready                 = s_q.pready;
	assign pslverr                = s_q.pslverr;
	assign flag_period_20ms       = s_q.flags[0];
	assign flag_period_100ms      = s_q.flags[1];
	assign flag_period_200ms      = s_q.flags[2];
	assign flag_period_one_second = s_q.flags[3];
	assign flag_period_one_minute = s_q.flags[4];
endmodule // pfg_top

// File: dv/pfg_checker.sv
// Port checks for the periodic flag generator
module pfg_checker #(parameter int unsigned TICK_CYCLES = 4) (
	input wire logic pclk, presetn, psel, penable, pready, pslverr,
	input wire logic flag_period_20ms, flag_period_100ms, flag_period_200ms,
	input wire logic flag_period_one_second, flag_period_one_minute
);
	int unsigned c;
	wire logic [4:0] f = {flag_period_one_minute, flag_period_one_second,
		flag_period_200ms, flag_period_100ms, flag_period_20ms};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles since the last 20 ms edge; clearing RUN mid-phase would trip it
	always_ff @(posedge pclk) c <= $changed(f[0]) ? 0 : c + 1;
	half_20ms_a: assert property ($fell(f[0]) |-> c == TICK_CYCLES - 1) else $error("half");
	base_100ms_a: assert property ($changed(f[1]) |-> $changed(f[0])) else $error("b1");
	base_200ms_a: assert property ($changed(f[2]) |-> $changed(f[1])) else $error("b2");
	base_second_a: assert property ($changed(f[3]) |-> $changed(f[2])) else $error("b3");
	base_minute_a: assert property ($changed(f[4]) |-> $changed(f[3])) else $error("b4");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pulse");
	error_ready_a: assert property (pslverr |-> pready) else $error("err");
	ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("wait");
endmodule // pfg_checker
bind pfg_top pfg_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// File: dv/pfg_tb_top.sv
// Self-checking bench for the periodic flag generator
module pfg_tb_top;
	timeunit 1ns / 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [4:0] f;
	int fails = 0, checks = 0;
	pfg_top #(.TICK_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .flag_period_20ms(f[0]),
		.flag_period_100ms(f[1]), .flag_period_200ms(f[2]),
		.flag_period_one_second(f[3]), .flag_period_one_minute(f[4]));
	initial forever #5 pclk = ~pclk;
	task chk(input logic [31:0] s, x);
		checks++;
		if (s !== x) begin fails++; $display("mismatch %0t %h %h", $time, s, x); end
	endtask
	// One transfer plus an idle cycle, so strobes never flip twice in a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk) penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask
	task automatic half(input int i);
		int n = 0;
		while (f[i] !== 1'h1) @(posedge pclk);
		for (; f[i] === 1'h1; n++) @(posedge pclk);
		chk(n, 4 * pfg_pkg::HALF_TICKS[i]);
	endtask
	// Status writes are dropped; an unmapped place answers with an error
	task t_ro;
		apb(1'h1, pfg_pkg::ADDR_FLAGS, 32'h1f);
		apb(1'h0, pfg_pkg::ADDR_FLAGS, 32'h0);
		chk(r, pfg_pkg::FLAGS_RESET);
		apb(1'h0, 12'hffc, 32'h0);
		chk(e, 1'h1);
	endtask
	// Start leaves all flags low; slower ones still low at the first 20 ms rise
	task t_start;
		apb(1'h1, pfg_pkg::ADDR_CTRL, 32'h1);
		chk(f, 5'h0);
		while (f[0] !== 1'h1) @(posedge pclk);
		chk(f, 5'h1);
	endtask
	// Flag writes while running must not disturb a flag that stands high
	task t_ro_run;
		while (f[1] !== 1'h1) @(posedge pclk);
		apb(1'h1, pfg_pkg::ADDR_FLAGS, 32'h0);
		apb(1'h0, pfg_pkg::ADDR_FLAGS, 32'h0);
		chk(r[1], 1'h1);
		chk(f[1], 1'h1);
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_ro();
		t_start();
		for (int i = 0; i < 5; i++) half(i);
		t_ro_run();
		stop_test();
	end
	// Longest flag needs about 24k cycles
	initial begin #400000; fails++; stop_test(); end
	task stop_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
endmodule // pfg_tb_top
